// ==== core/lacd_capture.sv ====
`timescale 1ns/1ps
`include "lacd_regs.svh"
// Contract
// - ddr formats register on both clock edges
// - bit-wise: odd and even halves interleaved
// - bit-wise: 16-bit sample on eight lanes
// - bit-wise path good to 250 MHz
// - sample-wise: one lane per sample bit
// - sample-wise: rise sample, then fall sample
// - sample-wise path good to 1 GHz
// - one-wire serial: resolution bits per frame
// - bit clock strobes and deserializes serial data
// - frame clock marks sample word boundaries
// - one bit and frame clock for all lanes
// - two-wire serial: two lanes, half rate each
// - parallel or serial capture, never both
// - store 16-bit words, 512M deep
// - read back, stream over spi to bridge
// - 35 data lanes, two clocks, eight gpio
// - bit clock rate set by format
// - frame lane sets the second bus edge phase
module lacd_capture (
   input  wire logic                      core_clk,
   input  wire logic                      rst_b,
   input  wire logic                      lvds_bit_clk,
   input  wire logic [`LACD_LANES-1:0]    lvds_data,
   input  wire logic                      lvds_frame,
   input  wire lacd_pkg::lacd_cfg_type    cfg,
   input  wire logic                      cap_start,
   input  wire logic [`LACD_ADDR_W-1:0]   cap_len,
   input  wire logic [`LACD_GPIO_N-1:0]   gp_ctl_in,
   output logic      [`LACD_GPIO_N-1:0]   gp_ctl_out,
   output lacd_pkg::lacd_mem_wr_type      mem_wr,
   input  wire logic                      mem_wr_ready,
   output logic                           mem_rd_req,
   output logic      [`LACD_ADDR_W-1:0]   mem_rd_addr,
   input  wire logic                      mem_rd_ready,
   input  wire logic                      mem_rd_valid,
   input  wire logic [`LACD_SMP_W-1:0]    mem_rd_data,
   output logic                           spi_sclk,
   output logic                           spi_mosi,
   output logic                           spi_cs_b,
   output logic                           busy,
   output logic                           overrun
);
   import lacd_pkg::*;

   function automatic logic [`LACD_SMP_W-1:0] lacd_ser_word(
      input logic [`LACD_SMP_W-1:0] a,
      input logic [`LACD_SMP_W-1:0] b,
      input lacd_res_type           r,
      input logic                   two);
      logic [`LACD_SMP_W-1:0] w;
      w = '0;
      case (r)
         LACD_RES12: w[`LACD_R12-1:0] = two ? {a[`LACD_R12/2-1:0], b[`LACD_R12/2-1:0]}
                                            : a[`LACD_R12-1:0];
         LACD_RES14: w[`LACD_R14-1:0] = two ? {a[`LACD_R14/2-1:0], b[`LACD_R14/2-1:0]}
                                            : a[`LACD_R14-1:0];
         default:    w = two ? {a[`LACD_SMP_W/2-1:0], b[`LACD_SMP_W/2-1:0]} : a;
      endcase
      return w;
   endfunction

   // ---------------- link domain ----------------
   logic [1:0]               link_rst_pipe;
   logic                     link_rst_b;
   logic                     l_en_s;
   logic                     l_en;
   lacd_cfg_type             l_cfg;
   logic [`LACD_LANES:0]     rise_q;
   logic [`LACD_LANES:0]     fall_q;
   logic                     fr_last;
   logic                     ser_arm;
   logic [`LACD_IDX_W-1:0]   cnt;
   lacd_grp_type             grp;
   lacd_grp_type             next_grp;
   lacd_grp_type             hold;
   lacd_grp_type             sh;
   lacd_grp_type             next_sh;
   lacd_grp_type             ser_grp;
   logic                     tog;
   logic                     cap_en;
   lacd_cfg_type             cfg_q;

   // release of the link reset is timed by the link clock itself
   always_ff @(posedge lvds_bit_clk or negedge rst_b) begin
      if (!rst_b) begin
         link_rst_pipe <= '0;
      end else begin
         link_rst_pipe <= {link_rst_pipe[0], 1'b1};
      end
   end
   assign link_rst_b = link_rst_pipe[1];

   // config loads on the same core edge that raises enable; l_en trails the synced enable by one link cycle
   lacd_sync2 #(.WIDTH($bits(lacd_cfg_type) + 1)) u_cfg_sync (
      .clk   (lvds_bit_clk),
      .rst_b (link_rst_b),
      .d     ({cap_en, cfg_q}),
      .q     ({l_en_s, l_cfg})
   );

   // single register stage per edge keeps both parallel paths at full rate
   always_ff @(posedge lvds_bit_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         rise_q <= '0;
      end else begin
         rise_q <= {lvds_frame, lvds_data};
      end
   end

   always_ff @(negedge lvds_bit_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         fall_q <= '0;
      end else begin
         fall_q <= {lvds_frame, lvds_data};
      end
   end

   wire              fr_hi     = rise_q[`LACD_LANES];
   wire              par_mode  = (l_cfg.fmt == LACD_BITWISE) || (l_cfg.fmt == LACD_SMPWISE)
                                 || (l_cfg.fmt == LACD_DUALBUS);
   wire              ser_mode  = (l_cfg.fmt == LACD_SER1W) || (l_cfg.fmt == LACD_SER2W);
   wire              two_w     = l_cfg.fmt == LACD_SER2W;
   wire              two_per   = l_cfg.fmt != LACD_BITWISE;
   wire [1:0]        step      = two_per ? `LACD_STEP_TWO : `LACD_STEP_ONE;
   wire [`LACD_IDX_W:0] cnt_sum = {1'b0, cnt} + {{(`LACD_IDX_W-1){1'b0}}, step};
   wire              fr_start  = fr_hi & ~fr_last;
   wire              par_commit = l_en & par_mode & cnt_sum[`LACD_IDX_W];
   wire              ser_commit = l_en & ser_mode & ser_arm & fr_start;

   logic [`LACD_SMP_W-1:0] bw_a;
   logic [`LACD_SMP_W-1:0] bw_b;
   wire  [`LACD_SMP_W-1:0] sw_0 = rise_q[`LACD_SMP_W-1:0];
   wire  [`LACD_SMP_W-1:0] sw_1 = fall_q[`LACD_SMP_W-1:0];
   wire  [`LACD_SMP_W-1:0] w0   = (l_cfg.fmt == LACD_SMPWISE) ? sw_0 : bw_a;
   wire  [`LACD_SMP_W-1:0] w1   = (l_cfg.fmt == LACD_SMPWISE) ? sw_1 : bw_b;

   // eight lanes carry a 16-bit sample: odd bits on the rise, even on the fall
   for (genvar i = 0; i < `LACD_SMP_W/2; i++) begin : g_bit
      assign bw_a[2*i+1] = rise_q[i];
      assign bw_a[2*i]   = fall_q[i];
      // second bus takes its edge phase from the frame lane
      assign bw_b[2*i+1] = fr_hi ? rise_q[i+`LACD_BUSB_LANE] : fall_q[i+`LACD_BUSB_LANE];
      assign bw_b[2*i]   = fr_hi ? fall_q[i+`LACD_BUSB_LANE] : rise_q[i+`LACD_BUSB_LANE];
   end

   // oldest sample sits in entry 0
   for (genvar e = 0; e < `LACD_GRP_N; e++) begin : g_ent
      if (e < `LACD_GRP_N-2) begin : g_mid
         assign next_grp[e] = two_per ? grp[e+2] : grp[e+1];
      end else if (e == `LACD_GRP_N-2) begin : g_pen
         assign next_grp[e] = two_per ? w0 : grp[e+1];
      end else begin : g_top
         assign next_grp[e] = two_per ? w1 : w0;
      end
      // each lane shifts two bits per bit-clock cycle, rise bit first
      assign next_sh[e] = {sh[e][`LACD_SMP_W-3:0], rise_q[e], fall_q[e]};
      if (e < `LACD_SER2_CH) begin : g_ch2
         assign ser_grp[e] = lacd_ser_word(two_w ? sh[2*e] : sh[e], sh[2*e+1],
                                           l_cfg.res, two_w);
      end else begin : g_ch1
         assign ser_grp[e] = two_w ? '0 : lacd_ser_word(sh[e], sh[e], l_cfg.res, 1'b0);
      end
   end

   always_ff @(posedge lvds_bit_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         l_en    <= 1'b0;
         fr_last <= 1'b0;
         sh      <= '0;
         ser_arm <= 1'b0;
      end else begin
         l_en    <= l_en_s;
         fr_last <= fall_q[`LACD_LANES];
         sh      <= next_sh;
         // first frame edge only arms, its word is partial
         ser_arm <= l_en & ser_mode & (ser_arm | fr_start);
      end
   end

   always_ff @(posedge lvds_bit_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         cnt <= '0;
         grp <= '0;
      end else if (!l_en || !par_mode) begin
         cnt <= '0;
      end else begin
         cnt <= cnt_sum[`LACD_IDX_W-1:0];
         grp <= next_grp;
      end
   end

   // hold stays put for a whole group, long enough for the core to copy it
   always_ff @(posedge lvds_bit_clk or negedge link_rst_b) begin
      if (!link_rst_b) begin
         hold <= '0;
         tog  <= 1'b0;
      end else if (par_commit || ser_commit) begin
         hold <= par_commit ? next_grp : ser_grp;
         tog  <= ~tog;
      end
   end

   // ---------------- core domain ----------------
   lacd_state_type          state;
   lacd_state_type          next_state;
   logic                    tog_s;
   logic                    tog_d;
   lacd_grp_type            buf_q;
   logic                    wr_busy;
   logic [`LACD_IDX_W-1:0]  widx;
   logic [`LACD_ADDR_W-1:0] waddr;
   logic [`LACD_ADDR_W-1:0] wcnt;
   logic [`LACD_ADDR_W-1:0] raddr;
   logic [`LACD_ADDR_W-1:0] cap_len_q;
   logic                    rd_issued;
   logic                    spi_go;
   logic [`LACD_SMP_W-1:0]  spi_word;
   logic                    spi_done;

   lacd_sync2 #(.WIDTH(1)) u_tog_sync (
      .clk   (core_clk),
      .rst_b (rst_b),
      .d     (tog),
      .q     (tog_s)
   );

   wire grp_valid = tog_s ^ tog_d;
   wire in_capt   = state == LACD_CAPT;
   wire wr_acc    = mem_wr.valid & mem_wr_ready;
   wire wr_free   = ~mem_wr.valid | wr_acc;
   wire wr_load   = wr_busy & wr_free & (waddr != cap_len_q);
   wire [`LACD_IDX_W-1:0] wr_last = (cfg_q.fmt == LACD_SER2W) ? `LACD_LAST_4 : `LACD_LAST_8;
   wire cap_full  = wcnt == cap_len_q;
   wire rd_last   = raddr == cap_len_q;

   always_comb begin
      next_state = state;
      case (state)
         LACD_IDLE:   if (cap_start) next_state = LACD_CAPT;
         LACD_CAPT:   if (cap_full) next_state = LACD_RDREQ;
         LACD_RDREQ: begin
            if (!rd_issued && rd_last) next_state = LACD_IDLE;
            else if (rd_issued && mem_rd_valid) next_state = LACD_RDSEND;
         end
         LACD_RDSEND: if (spi_done) next_state = LACD_RDREQ;
         default:     next_state = LACD_IDLE;
      endcase
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         state      <= LACD_IDLE;
         busy       <= 1'b0;
         cap_en     <= 1'b0;
         tog_d      <= 1'b0;
         gp_ctl_out <= '0;
      end else begin
         state      <= next_state;
         busy       <= next_state != LACD_IDLE;
         cap_en     <= next_state == LACD_CAPT;
         tog_d      <= tog_s;
         gp_ctl_out <= gp_ctl_in;
      end
   end

   // setup is taken only from idle and held for the whole run
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         cfg_q     <= '{fmt: LACD_BITWISE, res: LACD_RES16};
         cap_len_q <= '0;
      end else if (state == LACD_IDLE && cap_start) begin
         cfg_q     <= cfg;
         cap_len_q <= cap_len;
      end
   end

   // one-group buffer: a group arriving while the last one drains is dropped and flagged
   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         overrun <= 1'b0;
         wr_busy <= 1'b0;
         buf_q   <= '0;
      end else begin
         if (in_capt && grp_valid && wr_busy) begin
            overrun <= 1'b1;
         end else if (state == LACD_IDLE && cap_start) begin
            overrun <= 1'b0;
         end
         if (in_capt && grp_valid && !wr_busy) begin
            buf_q   <= hold;
            wr_busy <= 1'b1;
         end else if (!in_capt || (wr_load && widx == wr_last)) begin
            wr_busy <= 1'b0;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_wr <= '0;
         widx   <= '0;
         waddr  <= '0;
         wcnt   <= '0;
      end else if (state == LACD_IDLE) begin
         mem_wr.valid <= 1'b0;
         widx         <= '0;
         waddr        <= '0;
         wcnt         <= '0;
      end else begin
         if (wr_load) begin
            mem_wr <= '{valid: 1'b1, addr: waddr, data: buf_q[widx]};
            widx   <= widx + 1'b1;
            waddr  <= waddr + 1'b1;
         end else if (wr_acc) begin
            mem_wr.valid <= 1'b0;
         end
         if (!wr_busy) begin
            widx <= '0;
         end
         if (wr_acc) begin
            wcnt <= wcnt + 1'b1;
         end
      end
   end

   always_ff @(posedge core_clk or negedge rst_b) begin
      if (!rst_b) begin
         mem_rd_req  <= 1'b0;
         mem_rd_addr <= '0;
         rd_issued   <= 1'b0;
         raddr       <= '0;
         spi_go      <= 1'b0;
         spi_word    <= '0;
      end else begin
         spi_go      <= 1'b0;
         mem_rd_addr <= raddr;
         if (state == LACD_IDLE) begin
            raddr <= '0;
         end else if (state == LACD_RDSEND && spi_done) begin
            raddr <= raddr + 1'b1;
         end
         if (state == LACD_RDREQ && !rd_issued && !rd_last) begin
            mem_rd_req <= 1'b1;
            rd_issued  <= 1'b1;
         end else if (mem_rd_req && mem_rd_ready) begin
            mem_rd_req <= 1'b0;
         end
         if (state == LACD_RDREQ && rd_issued && mem_rd_valid) begin
            spi_word  <= mem_rd_data;
            spi_go    <= 1'b1;
            rd_issued <= 1'b0;
         end
      end
   end

   lacd_spi_tx u_spi (
      .clk   (core_clk),
      .rst_b (rst_b),
      .go    (spi_go),
      .word  (spi_word),
      .sclk  (spi_sclk),
      .mosi  (spi_mosi),
      .cs_b  (spi_cs_b),
      .done  (spi_done)
   );

   // ---------------- checks ----------------
   rise_cap_a: assert property (@(posedge lvds_bit_clk) disable iff (!link_rst_b)
      l_en |=> rise_q == $past({lvds_frame, lvds_data}))
      else $error("rising edge capture lost");

   fall_cap_a: assert property (@(negedge lvds_bit_clk) disable iff (!link_rst_b)
      l_en |=> fall_q == $past({lvds_frame, lvds_data}))
      else $error("falling edge capture lost");

   bit_interleave_a: assert property (@(posedge lvds_bit_clk) disable iff (!link_rst_b)
      (par_commit && l_cfg.fmt == LACD_BITWISE)
      |=> hold[`LACD_GRP_N-1][1] == $past(rise_q[0]) && hold[`LACD_GRP_N-1][0] == $past(fall_q[0]))
      else $error("bit-wise halves not interleaved");

   smp_order_a: assert property (@(posedge lvds_bit_clk) disable iff (!link_rst_b)
      (par_commit && l_cfg.fmt == LACD_SMPWISE)
      |=> hold[`LACD_GRP_N-2] == $past(sw_0) && hold[`LACD_GRP_N-1] == $past(sw_1))
      else $error("sample-wise order broken");

   frame_word_a: assert property (@(posedge lvds_bit_clk) disable iff (!link_rst_b)
      (l_en && ser_mode && ser_arm && fr_start) |=> tog != $past(tog))
      else $error("frame edge did not publish words");

   grp_strobe_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      grp_valid |=> !grp_valid ##1 !grp_valid)
      else $error("group strobe longer than one cycle");

   cfg_static_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (state != LACD_IDLE) |=> $stable(cfg_q) && $stable(cap_len_q))
      else $error("config changed during capture");

   wr_hold_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (mem_wr.valid && !mem_wr_ready && state != LACD_IDLE)
      |=> mem_wr.valid && $stable(mem_wr.addr) && $stable(mem_wr.data))
      else $error("memory write dropped before acceptance");

   rd_spi_a: assert property (@(posedge core_clk) disable iff (!rst_b)
      (state == LACD_RDREQ && rd_issued && mem_rd_valid)
      |=> spi_go && spi_word == $past(mem_rd_data) ##1 !spi_cs_b)
      else $error("read word not sent to spi");

endmodule

// ==== core/lacd_pkg.sv ====
package lacd_pkg;
`include "lacd_regs.svh"

   typedef enum logic [`LACD_FMT_W-1:0] {
      LACD_BITWISE = `LACD_FMT_BIT,
      LACD_SMPWISE = `LACD_FMT_SMP,
      LACD_DUALBUS = `LACD_FMT_DUAL,
      LACD_SER1W   = `LACD_FMT_SER1,
      LACD_SER2W   = `LACD_FMT_SER2
   } lacd_fmt_type;

   typedef enum logic [1:0] {
      LACD_RES12 = `LACD_RES_12,
      LACD_RES14 = `LACD_RES_14,
      LACD_RES16 = `LACD_RES_16
   } lacd_res_type;

   typedef struct packed {
      lacd_fmt_type fmt;
      lacd_res_type res;
   } lacd_cfg_type;

   typedef struct packed {
      logic                     valid;
      logic [`LACD_ADDR_W-1:0]  addr;
      logic [`LACD_SMP_W-1:0]   data;
   } lacd_mem_wr_type;

   typedef enum logic [1:0] {
      LACD_IDLE   = `LACD_ST_IDLE,
      LACD_CAPT   = `LACD_ST_CAPT,
      LACD_RDREQ  = `LACD_ST_RDREQ,
      LACD_RDSEND = `LACD_ST_RDSEND
   } lacd_state_type;

   typedef logic [`LACD_GRP_N-1:0][`LACD_SMP_W-1:0] lacd_grp_type;

endpackage

// ==== core/lacd_regs.svh ====
`ifndef LACD_REGS_SVH
`define LACD_REGS_SVH

`define LACD_LANES      35
`define LACD_GPIO_N     8
`define LACD_SMP_W      16
`define LACD_GRP_N      8
`define LACD_IDX_W      3
`define LACD_SER2_CH    4
`define LACD_ADDR_W     29
`define LACD_BUSB_LANE  8

`define LACD_FMT_W      3
`define LACD_FMT_BIT    3'h0
`define LACD_FMT_SMP    3'h1
`define LACD_FMT_DUAL   3'h2
`define LACD_FMT_SER1   3'h3
`define LACD_FMT_SER2   3'h4

`define LACD_RES_12     2'h0
`define LACD_RES_14     2'h1
`define LACD_RES_16     2'h2
`define LACD_R12        12
`define LACD_R14        14

`define LACD_ST_IDLE    2'h0
`define LACD_ST_CAPT    2'h1
`define LACD_ST_RDREQ   2'h3
`define LACD_ST_RDSEND  2'h2

`define LACD_STEP_ONE   2'h1
`define LACD_STEP_TWO   2'h2
`define LACD_LAST_8     3'h7
`define LACD_LAST_4     3'h3

`define LACD_SPI_CNT_W  5
`define LACD_SPI_BITS   5'h10
`define LACD_SPI_LAST   5'h01

`define LACD_BW_MAX_MHZ 250
`define LACD_SW_MAX_MHZ 1000

`endif

// ==== core/lacd_spi_tx.sv ====
`timescale 1ns/1ps
`include "lacd_regs.svh"
module lacd_spi_tx (
   input  wire logic                   clk,
   input  wire logic                   rst_b,
   input  wire logic                   go,
   input  wire logic [`LACD_SMP_W-1:0] word,
   output logic                        sclk,
   output logic                        mosi,
   output logic                        cs_b,
   output logic                        done
);
   import lacd_pkg::*;

   logic [`LACD_SMP_W-1:0]    shreg;
   logic [`LACD_SPI_CNT_W-1:0] bits;
   logic                      active;

   // mode 0, msb first, sclk at half the core rate so the bridge sees clean edges
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         sclk   <= 1'b0;
         mosi   <= 1'b0;
         cs_b   <= 1'b1;
         done   <= 1'b0;
         active <= 1'b0;
         bits   <= '0;
         shreg  <= '0;
      end else begin
         done <= 1'b0;
         if (!active) begin
            if (go) begin
               active <= 1'b1;
               cs_b   <= 1'b0;
               shreg  <= word;
               mosi   <= word[`LACD_SMP_W-1];
               bits   <= `LACD_SPI_BITS;
            end
         end else if (!sclk) begin
            sclk <= 1'b1;
         end else begin
            sclk <= 1'b0;
            if (bits == `LACD_SPI_LAST) begin
               active <= 1'b0;
               cs_b   <= 1'b1;
               done   <= 1'b1;
            end else begin
               mosi  <= shreg[`LACD_SMP_W-2];
               shreg <= {shreg[`LACD_SMP_W-2:0], 1'b0};
               bits  <= bits - `LACD_SPI_LAST;
            end
         end
      end
   end
endmodule

// ==== core/lacd_sync2.sv ====
`timescale 1ns/1ps
module lacd_sync2 #(
   parameter int WIDTH = 1
) (
   input  wire logic             clk,
   input  wire logic             rst_b,
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);
   logic [WIDTH-1:0] meta;

   // first stage feeds only the second
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// ==== verif/lacd_adc_model.sv ====
`timescale 1ns/1ps
`include "lacd_regs.svh"
module lacd_adc_model (
   input  wire lacd_pkg::lacd_fmt_type fmt,
   output logic                        bit_clk,
   output logic [`LACD_LANES-1:0]      data,
   output logic                        frame
);
   import lacd_pkg::*;
   logic [15:0] s = 16'h0;
   logic [11:0] f = 12'h0;
   int          k = 0;
   // one bit clock and one frame lane shared by every lane
   function automatic logic [35:0] lanes(input int h);
      logic [34:0] d;
      logic [15:0] w;
      logic        fr;
      // unused lanes toggle so a stale level never looks like data
      d = {35{1'(h) ^ k[0]}};
      fr = 1'b0;
      case (fmt)
         LACD_SMPWISE: d[15:0] = s + 16'(h);
         LACD_SER1W: begin
            for (int c = 0; c < 8; c++) begin
               w = {c[3:0], f};
               d[c] = w[15-2*k-h];
            end
            fr = (k < 4);
         end
         LACD_SER2W: begin
            for (int c = 0; c < 4; c++) begin
               w = {c[3:0], f};
               d[2*c] = w[15-2*k-h];
               d[2*c+1] = w[7-2*k-h];
            end
            fr = (k < 2);
         end
         default: begin
            // dual-bus: bus b carries the inverse, frame lane high puts its odd bits on the rise
            for (int i = 0; i < 8; i++) begin
               d[i] = s[2*i+1-h];
               d[i+8] = ~s[2*i+1-h];
            end
            fr = (fmt == LACD_DUALBUS);
         end
      endcase
      return {fr, d};
   endfunction
   // free-running clock at the sample rate for bit-wise and dual-bus, at half the sample rate for sample-wise
   initial begin
      bit_clk = 1'b0;
      {frame, data} = lanes(0);
      forever begin
         #1.5 bit_clk = 1'b1;
         #1.5 {frame, data} = lanes(1);
         #1.5 bit_clk = 1'b0;
         #1.5 k++;
         // a format switch mid-frame can leave k past the new frame length
         if (k >= ((fmt == LACD_SER1W) ? 8 : (fmt == LACD_SER2W) ? 4 : 1)) begin
            k = 0;
            f++;
            s = s + ((fmt == LACD_SMPWISE) ? 16'h2 : 16'h1);
         end
         {frame, data} = lanes(0);
      end
   end
endmodule

// ==== verif/lvds_adc_capture_deserializer_tb_top.sv ====
`timescale 1ns/1ps
`include "lacd_regs.svh"
module lvds_adc_capture_deserializer_tb_top;
   import lacd_pkg::*;
   logic                    core_clk = 1'b0;
   logic                    rst_b = 1'b0;
   logic                    bclk;
   logic                    lframe;
   logic [`LACD_LANES-1:0]  ldata;
   lacd_fmt_type            mfmt = LACD_BITWISE;
   lacd_cfg_type            cfg = '0;
   logic                    cap_start = 1'b0;
   logic [`LACD_ADDR_W-1:0] cap_len = '0;
   logic [7:0]              gin = 8'h0;
   logic [7:0]              gout;
   lacd_mem_wr_type         mem_wr;
   logic                    wr_rdy = 1'b0;
   logic                    rd_req;
   logic                    rd_rdy = 1'b0;
   logic                    rd_vld = 1'b0;
   logic                    acc = 1'b0;
   logic [`LACD_ADDR_W-1:0] rd_addr;
   logic [`LACD_ADDR_W-1:0] a_addr = '0;
   logic [15:0]             rd_data = 16'h0;
   logic [15:0]             sh = 16'h0;
   logic [15:0]             mem[int];
   logic [15:0]             rxq[$];
   logic                    sclk, mosi, cs_b, busy, overrun;
   int                      wcnt = 0, cyc = 0, num_errors = 0, checks_done = 0;

   always #2.5 core_clk = ~core_clk;

   lacd_capture u_dut (.core_clk(core_clk), .rst_b(rst_b), .lvds_bit_clk(bclk),
      .lvds_data(ldata), .lvds_frame(lframe), .cfg(cfg), .cap_start(cap_start),
      .cap_len(cap_len), .gp_ctl_in(gin), .gp_ctl_out(gout), .mem_wr(mem_wr),
      .mem_wr_ready(wr_rdy), .mem_rd_req(rd_req), .mem_rd_addr(rd_addr),
      .mem_rd_ready(rd_rdy), .mem_rd_valid(rd_vld), .mem_rd_data(rd_data),
      .spi_sclk(sclk), .spi_mosi(mosi), .spi_cs_b(cs_b), .busy(busy), .overrun(overrun));

   lacd_adc_model u_adc (.fmt(mfmt), .bit_clk(bclk), .data(ldata), .frame(lframe));

   task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic chk1(input logic got, input logic exp);
      chk16({15'h0, got}, {15'h0, exp});
   endtask

   // memory stand-in: stalls writes and reads on a fixed pattern
   always @(posedge core_clk) begin
      if (mem_wr.valid === 1'b1 && wr_rdy) begin
         chk16(16'(mem_wr.addr), 16'(wcnt));
         mem[wcnt] = mem_wr.data;
         wcnt++;
      end
      acc <= rd_req && rd_rdy;
      a_addr <= rd_addr;
   end
   always @(negedge core_clk) begin
      cyc++;
      wr_rdy <= (cyc % 3 != 0);
      rd_rdy <= cyc[1];
      rd_vld <= acc;
      rd_data <= acc ? mem[a_addr] : ~rd_data;
   end
   // host bridge side: mode 0, msb first
   always @(posedge sclk) if (!cs_b) sh <= {sh[14:0], mosi};
   always @(posedge cs_b) if (rst_b) rxq.push_back(sh);

   task automatic run_cap(input lacd_fmt_type f, input lacd_res_type r, input int len);
      int i;
      @(negedge core_clk);
      mfmt = f;
      cfg.fmt = f;
      cfg.res = r;
      cap_len = 29'(len);
      wcnt = 0;
      rxq.delete();
      cap_start = 1'b1;
      @(negedge core_clk);
      cap_start = 1'b0;
      chk1(busy, 1'b1);
      // a format switch and a second start mid-run must both be ignored
      cfg.fmt = (f == LACD_BITWISE) ? LACD_SER1W : LACD_BITWISE;
      repeat (5) @(negedge core_clk);
      cap_start = 1'b1;
      @(negedge core_clk);
      cap_start = 1'b0;
      for (i = 0; i < 12000 && busy; i++) @(negedge core_clk);
      chk1(busy, 1'b0);
      chk16(16'(wcnt), 16'(len));
      chk16(16'(rxq.size()), 16'(len));
      for (i = 0; i < len && i < rxq.size(); i++) chk16(rxq[i], mem[i]);
      $display("test fmt=%0d done", f);
   endtask

   task automatic t_gpio;
      gin = 8'ha5;
      @(negedge core_clk);
      chk16({8'h0, gout}, 16'h00a5);
      $display("test gpio done");
   endtask

   task automatic t_par(input lacd_fmt_type f);
      run_cap(f, LACD_RES16, 16);
      for (int i = 1; i < 16; i++) begin
         if (f != LACD_DUALBUS && i % 8 != 0)
            chk16(mem[i], 16'(mem[i-1] + 16'h1));
         if (f == LACD_DUALBUS && i % 2 == 1)
            chk16(mem[i], ~mem[i-1]);
         if (f == LACD_DUALBUS && i % 8 > 1 && i % 2 == 0)
            chk16(mem[i], 16'(mem[i-2] + 16'h1));
      end
      if (f == LACD_SMPWISE) chk1(overrun, 1'b1);
   endtask

   task automatic t_ser(input lacd_fmt_type f, input int g, input lacd_res_type r);
      run_cap(f, r, 2 * g);
      for (int i = 0; i < 2 * g; i++) begin
         // 12-bit words keep only the last twelve bits, so the channel nibble reads zero
         chk16({12'h0, mem[i][15:12]}, (r == LACD_RES16) ? 16'(i % g) : 16'h0);
         if (i % g != 0) chk16({4'h0, mem[i][11:0]}, {4'h0, mem[i-1][11:0]});
      end
   endtask

   task automatic complete_run;
      $display("checks=%0d errors=%0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   initial begin
      repeat (20) @(negedge core_clk);
      rst_b = 1'b1;
      t_gpio();
      t_par(LACD_BITWISE);
      t_par(LACD_DUALBUS);
      t_ser(LACD_SER1W, 8, LACD_RES16);
      t_ser(LACD_SER1W, 8, LACD_RES12);
      t_ser(LACD_SER2W, 4, LACD_RES16);
      t_par(LACD_SMPWISE);
      complete_run();
   end

   // six captures of at most 12000 cycles each bound the run
   initial begin
      #380us;
      num_errors++;
      complete_run();
   end
endmodule
